// file: design/mprs_device.sv
// Module end: power state, reset handling and serial handshake indicators
// What this block and the host do
// [RL1] Host holds power-on low at least 25 ms
// [RL2] Power-on input idles high via pull-up
// [RL3] Host waits 2000 ms after power-on edge
// [RL4] Power-on line never powers the module off
// [RL5] Host sends a 10 ms reset pulse
// [RL6] Reset restarts if power-on low, else off
// [RL7] Reset clears processor state and memory
// [RL8] Reset ignored while module is off
// [RL9] Host waits 2000 ms after reset edge
// [RL10] Supply status low off, high when on
// [RL11] Terminal ready blocks sleep, wakes, toggles mode
// [RL12] Sleep setting 1 enables wake line wakeup
// [RL13] Interface-on indicator set while serial on
// [RL14] Host times with own counters, syncs status
`timescale 1ns/1ps
module mprs_device #(
  parameter longint unsigned PWR_ON_CYC = mprs_pkg::PWR_ON_CYC_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  mprs_if.device_mp        link,
  input  wire logic        sleep_wake_setting,
  input  wire logic        sleep_request,
  input  wire logic        comm_active,
  input  wire logic        power_off_command,
  output logic             data_mode,
  output logic             state_cleared,
  output logic [3:0]       power_state
);

  // ---------------------------------------------------------------
  // Pin resolution and three-stage synchronisers
  // ---------------------------------------------------------------
  logic pwr_pin;
  logic rst_pin;
  logic [2:0] pwr_sync_q;
  logic [2:0] rst_sync_q;
  logic [2:0] dtr_sync_q;
  logic [2:0] wake_sync_q;
  logic pwr_n_q;
  logic rst_n_q;
  logic dtr_n_q;
  logic wake_q;
  logic rst_prev_q;
  logic dtr_prev_q;
  logic wake_prev_q;
  logic [mprs_pkg::CNT_W-1:0] pwr_cnt_q;
  logic pwr_valid_q;
  mprs_pkg::mprs_dev_state_e state_q;

  // Pull-up: line reads high unless the host pulls it low
  assign pwr_pin = ~link.power_on_request_n_oe;  // RL2
  assign rst_pin = ~link.reset_request_n_oe;

  // Synchroniser chains; first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_sync_q  <= 3'h7;
      rst_sync_q  <= 3'h7;
      dtr_sync_q  <= 3'h7;
      wake_sync_q <= 3'h0;
    end
    else
    begin
      pwr_sync_q  <= {pwr_sync_q[1:0], pwr_pin};
      rst_sync_q  <= {rst_sync_q[1:0], rst_pin};
      dtr_sync_q  <= {dtr_sync_q[1:0], link.terminal_ready_n};
      wake_sync_q <= {wake_sync_q[1:0], link.wake_request_line};
    end
  end

  // Filtered levels change once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_n_q <= 1'b1;
      rst_n_q <= 1'b1;
      dtr_n_q <= 1'b1;
      wake_q  <= 1'b0;
    end
    else
    begin
      if (pwr_sync_q[1] == pwr_sync_q[2])
        pwr_n_q <= pwr_sync_q[2];
      if (rst_sync_q[1] == rst_sync_q[2])
        rst_n_q <= rst_sync_q[2];
      if (dtr_sync_q[1] == dtr_sync_q[2])
        dtr_n_q <= dtr_sync_q[2];
      if (wake_sync_q[1] == wake_sync_q[2])
        wake_q <= wake_sync_q[2];
    end
  end

  // Edge history of filtered levels
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_prev_q  <= 1'b1;
      dtr_prev_q  <= 1'b1;
      wake_prev_q <= 1'b0;
    end
    else
    begin
      rst_prev_q  <= rst_n_q;
      dtr_prev_q  <= dtr_n_q;
      wake_prev_q <= wake_q;
    end
  end

  logic rst_fall;
  logic dtr_fall;
  logic wake_act;
  assign rst_fall = rst_prev_q & ~rst_n_q;
  assign dtr_fall = dtr_prev_q & ~dtr_n_q;
  assign wake_act = wake_q ^ wake_prev_q;

  // ---------------------------------------------------------------
  // Power-on assertion timer
  // ---------------------------------------------------------------
  // Short glitches on the power-on line must not start the module
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_cnt_q   <= '0;
      pwr_valid_q <= 1'b0;
    end
    else if (pwr_n_q)
    begin
      pwr_cnt_q   <= '0;
      pwr_valid_q <= 1'b0;
    end
    else if (pwr_cnt_q >= PWR_ON_CYC[mprs_pkg::CNT_W-1:0] - 1'b1)
      pwr_valid_q <= 1'b1;
    else
      pwr_cnt_q <= pwr_cnt_q + 1'b1;
  end

  // ---------------------------------------------------------------
  // Power state machine
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= mprs_pkg::MPRS_DEV_OFF;
    else
    begin
      case (state_q)
        mprs_pkg::MPRS_DEV_OFF:
          // Reset line has no effect here; only power-on starts
          if (pwr_valid_q)  // RL8
            state_q <= mprs_pkg::MPRS_DEV_IDLE;
        mprs_pkg::MPRS_DEV_IDLE,
        mprs_pkg::MPRS_DEV_COMM,
        mprs_pkg::MPRS_DEV_SLEEP:
          // Power-on line is never a power-off source
          if (power_off_command)  // RL4
            state_q <= mprs_pkg::MPRS_DEV_OFF;
          else if (rst_fall)
            state_q <= pwr_n_q ? mprs_pkg::MPRS_DEV_OFF
                               : mprs_pkg::MPRS_DEV_IDLE;  // RL6
          else if (state_q == mprs_pkg::MPRS_DEV_SLEEP)
          begin
            if (!dtr_n_q || (sleep_wake_setting && wake_act))  // RL11 RL12
              state_q <= mprs_pkg::MPRS_DEV_IDLE;
          end
          else if (comm_active)
            state_q <= mprs_pkg::MPRS_DEV_COMM;
          else if (sleep_request && dtr_n_q)  // RL11
            state_q <= mprs_pkg::MPRS_DEV_SLEEP;
          else
            state_q <= mprs_pkg::MPRS_DEV_IDLE;
        default:
          state_q <= mprs_pkg::MPRS_DEV_OFF;
      endcase
    end
  end

  // Reset flag marks cleared processor and memory state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_cleared <= 1'b0;
    else if (state_q != mprs_pkg::MPRS_DEV_OFF && rst_fall)
      state_cleared <= 1'b1;  // RL7
    else if (state_q == mprs_pkg::MPRS_DEV_OFF && pwr_valid_q)
      state_cleared <= 1'b0;
  end

  // Terminal-ready assertion toggles data and command mode
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      data_mode <= 1'b0;
    else if (state_q == mprs_pkg::MPRS_DEV_OFF || rst_fall)
      data_mode <= 1'b0;
    else if (dtr_fall)
      data_mode <= ~data_mode;  // RL11
  end

  // ---------------------------------------------------------------
  // Status outputs, registered
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.io_supply_status       <= 1'b0;
      link.interface_on_indicator <= 1'b0;
    end
    else
    begin
      link.io_supply_status       <= (state_q != mprs_pkg::MPRS_DEV_OFF);  // RL10
      link.interface_on_indicator <= (state_q == mprs_pkg::MPRS_DEV_IDLE) ||
                                     (state_q == mprs_pkg::MPRS_DEV_COMM);  // RL13
    end
  end

  assign power_state = state_q;

endmodule

// file: design/mprs_host.sv
// Host end: times power-on and reset pulses and waits for the module
`timescale 1ns/1ps
module mprs_host #(
  parameter longint unsigned PWR_ON_CYC   = mprs_pkg::PWR_ON_CYC_DEF,
  parameter longint unsigned RESET_CYC    = mprs_pkg::RESET_CYC_DEF,
  parameter longint unsigned POWER_UP_CYC = mprs_pkg::POWER_UP_CYC_DEF
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  mprs_if.host_mp          link,
  input  wire logic        power_on_start,
  input  wire logic        reset_start,
  input  wire logic        keep_awake,
  input  wire logic        wake_toggle,
  output logic             busy,
  output logic             module_ready,
  output logic             module_on
);

  // ---------------------------------------------------------------
  // Status synchroniser, three stages, agree on two and three
  // ---------------------------------------------------------------
  logic [2:0] vio_sync_q;
  logic       vio_q;
  logic [mprs_pkg::CNT_W-1:0] cnt_q;
  logic       wake_q;
  mprs_pkg::mprs_host_state_e state_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vio_sync_q <= 3'h0;
      vio_q      <= 1'b0;
    end
    else
    begin
      vio_sync_q <= {vio_sync_q[1:0], link.io_supply_status};
      if (vio_sync_q[1] == vio_sync_q[2])
        vio_q <= vio_sync_q[2];  // RL14
    end
  end

  // ---------------------------------------------------------------
  // Sequencer: pulse widths and power-up waits on own counter
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= mprs_pkg::MPRS_HST_IDLE;
      cnt_q   <= '0;
    end
    else
    begin
      case (state_q)
        mprs_pkg::MPRS_HST_IDLE,
        mprs_pkg::MPRS_HST_READY:
        begin
          cnt_q <= '0;
          if (power_on_start)
            state_q <= mprs_pkg::MPRS_HST_PULSE;
          else if (reset_start && vio_q)
            state_q <= mprs_pkg::MPRS_HST_RST;
        end
        mprs_pkg::MPRS_HST_PULSE:
          if (cnt_q == PWR_ON_CYC[mprs_pkg::CNT_W-1:0] - 1'b1)  // RL1
          begin
            cnt_q   <= '0;
            state_q <= mprs_pkg::MPRS_HST_WAIT;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        mprs_pkg::MPRS_HST_RST:
          if (cnt_q == RESET_CYC[mprs_pkg::CNT_W-1:0] - 1'b1)  // RL5
          begin
            // Restart the count so the full wait follows the reset edge
            cnt_q   <= '0;
            state_q <= mprs_pkg::MPRS_HST_WAIT;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        mprs_pkg::MPRS_HST_WAIT:
          // Wait counts from the falling edge of the pulse
          if (cnt_q >= POWER_UP_CYC[mprs_pkg::CNT_W-1:0] - 1'b1)  // RL3 RL9
            state_q <= vio_q ? mprs_pkg::MPRS_HST_READY : mprs_pkg::MPRS_HST_IDLE;
          else
            cnt_q <= cnt_q + 1'b1;
        default:
          state_q <= mprs_pkg::MPRS_HST_IDLE;
      endcase
    end
  end

  // Wake line toggles on request
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      wake_q <= 1'b0;
    else if (wake_toggle)
      wake_q <= ~wake_q;
  end

  // Open-drain pulls; power-on held low through the reset pulse too
  assign link.power_on_request_n_oe = (state_q == mprs_pkg::MPRS_HST_PULSE) ||
                                      (state_q == mprs_pkg::MPRS_HST_RST);
  assign link.reset_request_n_oe = (state_q == mprs_pkg::MPRS_HST_RST);
  assign link.terminal_ready_n   = ~keep_awake;
  assign link.wake_request_line  = wake_q;
  assign busy         = (state_q != mprs_pkg::MPRS_HST_IDLE) &&
                        (state_q != mprs_pkg::MPRS_HST_READY);
  assign module_ready = (state_q == mprs_pkg::MPRS_HST_READY);
  assign module_on    = vio_q;

endmodule

// file: design/mprs_if.sv
// Interface carrying the control lines between host and module
`timescale 1ns/1ps
interface mprs_if;
  // Open-drain requests: driven low by the host when enabled
  logic power_on_request_n_oe;
  logic reset_request_n_oe;
  logic terminal_ready_n;
  logic wake_request_line;
  logic io_supply_status;
  logic interface_on_indicator;

  modport device_mp (
    input  power_on_request_n_oe,
    input  reset_request_n_oe,
    input  terminal_ready_n,
    input  wake_request_line,
    output io_supply_status,
    output interface_on_indicator
  );

  modport host_mp (
    output power_on_request_n_oe,
    output reset_request_n_oe,
    output terminal_ready_n,
    output wake_request_line,
    input  io_supply_status,
    input  interface_on_indicator
  );
endinterface

// file: design/mprs_pkg.sv
// Shared constants and types for the module power and reset sequencer
package mprs_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned PS_PER_MS       = 1000000000;
  localparam int unsigned PWR_ON_MIN_MS   = 25;
  localparam int unsigned RESET_PULSE_MS  = 10;
  localparam int unsigned POWER_UP_MIN_MS = 2000;
  // Cycle counts, least times rounded up
  localparam longint unsigned PWR_ON_CYC_DEF =
    (longint'(PWR_ON_MIN_MS) * PS_PER_MS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint unsigned RESET_CYC_DEF =
    (longint'(RESET_PULSE_MS) * PS_PER_MS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint unsigned POWER_UP_CYC_DEF =
    (longint'(POWER_UP_MIN_MS) * PS_PER_MS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 32;

  // ---------------------------------------------------------------
  // Device power states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    MPRS_DEV_OFF   = 4'h1,
    MPRS_DEV_IDLE  = 4'h2,
    MPRS_DEV_COMM  = 4'h4,
    MPRS_DEV_SLEEP = 4'h8
  } mprs_dev_state_e;

  // ---------------------------------------------------------------
  // Host sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    MPRS_HST_IDLE  = 5'h01,
    MPRS_HST_PULSE = 5'h02,
    MPRS_HST_WAIT  = 5'h04,
    MPRS_HST_READY = 5'h08,
    MPRS_HST_RST   = 5'h10
  } mprs_host_state_e;

endpackage

// file: verification/module_power_reset_sequencer_tb.sv
// Testbench joining host and module ends through the control-line interface
`timescale 1ns/1ps
module module_power_reset_sequencer_tb;
  typedef struct {int kind; logic [3:0] exp;} mprs_note_s;
  logic        core_clk, rst_n, wake_set, sleep_req, comm_act, off_cmd;
  logic        pon_start, rst_start, keep_awake, wake_toggle;
  logic        busy, module_ready, module_on, data_mode, state_cleared;
  logic [3:0]  power_state;
  logic [31:0] seed;
  int          miscompares, check_count, rises, n;
  mprs_note_s  notes[$];
  mprs_note_s  nt;
  event        chk;
  mprs_if      link ();

  mprs_host #(.PWR_ON_CYC(20), .RESET_CYC(10), .POWER_UP_CYC(100)) i_mprs_host (
    .core_clk(core_clk), .rst_n(rst_n), .link(link), .power_on_start(pon_start),
    .reset_start(rst_start), .keep_awake(keep_awake), .wake_toggle(wake_toggle),
    .busy(busy), .module_ready(module_ready), .module_on(module_on));
  mprs_device #(.PWR_ON_CYC(20)) i_mprs_device (
    .core_clk(core_clk), .rst_n(rst_n), .link(link), .sleep_wake_setting(wake_set),
    .sleep_request(sleep_req), .comm_active(comm_act), .power_off_command(off_cmd),
    .data_mode(data_mode), .state_cleared(state_cleared), .power_state(power_state));
  mprs_monitor i_mprs_monitor (
    .core_clk(core_clk), .rst_n(rst_n),
    .power_on_request_n_oe(link.power_on_request_n_oe),
    .reset_request_n_oe(link.reset_request_n_oe),
    .terminal_ready_n(link.terminal_ready_n), .wake_request_line(link.wake_request_line),
    .io_supply_status(link.io_supply_status),
    .interface_on_indicator(link.interface_on_indicator));

  // Free-running 200 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task cyc(int c);
    repeat (c) @(posedge core_clk);
  endtask
  task note(int k, logic [3:0] e);
    notes.push_back('{k, e});
  endtask
  task cmp_bit(string name, logic e, logic g);
    check_count++;
    if (g !== e)
    begin
      $display("wrong value %s expected %0b seen %0b", name, e, g);
      miscompares++;
    end
  endtask
  task cmp_state(string name, logic [3:0] e, logic [3:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", name, e, g);
      miscompares++;
    end
  endtask
  // One-cycle request pulse; the extra edge keeps strobes apart
  task go(int w);
    case (w)
      0: pon_start <= 1'b1;
      1: rst_start <= 1'b1;
      2: wake_toggle <= 1'b1;
      default: off_cmd <= 1'b1;
    endcase
    cyc(1);
    {pon_start, rst_start, wake_toggle, off_cmd} <= 4'h0;
    cyc(1);
  endtask
  // Bounded wait; running out counts as a mismatch
  task wait_ready();
    int i;
    for (i = 0; i < 1000 && !(module_ready === 1'b1 && busy === 1'b0); i++)
      cyc(1);
    if (i == 1000)
    begin
      $display("wrong value module_ready expected 1 seen 0");
      miscompares++;
      final_report();
    end
  endtask
  task final_report();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  // Watcher: compares every pending note against the outputs now
  always @(chk)
  begin
    // Read mid-cycle so every register of the last edge has settled
    @(negedge core_clk);
    while (notes.size() > 0)
    begin
      nt = notes.pop_front();
      case (nt.kind)
        0: cmp_bit("module_ready", nt.exp[0], module_ready);
        1: cmp_bit("module_on", nt.exp[0], module_on);
        2: cmp_state("power_state", nt.exp, power_state);
        3: cmp_bit("state_cleared", nt.exp[0], state_cleared);
        4: cmp_bit("data_mode", nt.exp[0], data_mode);
        5: cmp_bit("interface_on", nt.exp[0], link.interface_on_indicator);
        default: cmp_bit("io_supply", nt.exp[0], link.io_supply_status);
      endcase
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {rst_n, wake_set, sleep_req, comm_act, off_cmd} = 5'h00;
    {pon_start, rst_start, keep_awake, wake_toggle} = 4'h0;
    {miscompares, check_count, rises} = '0;
    seed = 32'h000133FE;
    cyc(3);
    rst_n <= 1'b1;
    cyc(2);
    go(1);
    cyc(12);
    note(6, 4'h0);
    note(2, 4'h1);
    ->chk;
    go(0);
    wait_ready();
    note(1, 4'h1);
    note(6, 4'h1);
    note(2, 4'h2);
    note(5, 4'h1);
    note(3, 4'h0);
    ->chk;
    // Terminal ready goes first so the sleep request first meets it held
    keep_awake <= 1'b1;
    rises++;
    cyc(6);
    sleep_req <= 1'b1;
    cyc(12);
    note(2, 4'h2);
    ->chk;
    keep_awake <= 1'b0;
    cyc(12);
    note(2, 4'h8);
    note(5, 4'h0);
    ->chk;
    // Wake line activity must be ignored while the sleep setting is off
    go(2);
    cyc(12);
    note(2, 4'h8);
    ->chk;
    wake_set <= 1'b1;
    sleep_req <= 1'b0;
    go(2);
    cyc(12);
    note(2, 4'h2);
    ->chk;
    comm_act <= 1'b1;
    cyc(12);
    note(2, 4'h4);
    note(6, 4'h1);
    ->chk;
    comm_act <= 1'b0;
    // Random number of mode switches with random gaps
    seed = xs(seed);
    n = 1 + int'(seed[1:0]);
    repeat (n)
    begin
      keep_awake <= 1'b1;
      seed = xs(seed);
      cyc(6 + int'(seed[2:0]));
      keep_awake <= 1'b0;
      cyc(6);
    end
    rises += n;
    note(4, {3'h0, rises[0]});
    ->chk;
    go(0);
    wait_ready();
    note(6, 4'h1);
    ->chk;
    go(1);
    wait_ready();
    note(3, 4'h1);
    note(6, 4'h1);
    note(0, 4'h1);
    ->chk;
    go(3);
    cyc(12);
    note(6, 4'h0);
    note(2, 4'h1);
    note(5, 4'h0);
    note(1, 4'h0);
    ->chk;
    cyc(1);
    final_report();
  end
endmodule

// file: verification/mprs_monitor.sv
// Checker on the control lines between host and module ends
`timescale 1ns/1ps
module mprs_monitor #(
  parameter longint unsigned PWR_ON_CYC = 20,
  parameter longint unsigned RESET_CYC  = 10
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic power_on_request_n_oe,
  input wire logic reset_request_n_oe,
  input wire logic terminal_ready_n,
  input wire logic wake_request_line,
  input wire logic io_supply_status,
  input wire logic interface_on_indicator
);
  logic [7:0] pon_cnt_q;
  logic [7:0] rst_cnt_q;
  logic [7:0] since_q;
  logic       with_rst_q;

  // ------------------------------------------------------------
  // Helper counters
  // ------------------------------------------------------------
  // Widths of both pulses and cycles since power-on was last driven
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pon_cnt_q  <= 8'h00;
      rst_cnt_q  <= 8'h00;
      since_q    <= 8'hFF;
      with_rst_q <= 1'b0;
    end
    else
    begin
      pon_cnt_q  <= power_on_request_n_oe ? pon_cnt_q + 8'h01 : 8'h00;
      rst_cnt_q  <= reset_request_n_oe ? rst_cnt_q + 8'h01 : 8'h00;
      since_q    <= power_on_request_n_oe ? 8'h00 : since_q + {7'h00, since_q != 8'hFF};
      // A power-on drive that spans a reset is no ignition pulse
      with_rst_q <= power_on_request_n_oe && (with_rst_q || reset_request_n_oe);
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_pon_width;
    $fell(power_on_request_n_oe) && !with_rst_q |-> pon_cnt_q >= PWR_ON_CYC;
  endproperty
  a_pon_width: assert property (p_pon_width)
    else $error("power-on pulse too short");
  property p_rst_width;
    $fell(reset_request_n_oe) |-> rst_cnt_q >= RESET_CYC;
  endproperty
  a_rst_width: assert property (p_rst_width)
    else $error("reset pulse too short");
  property p_rst_only_on;
    $rose(reset_request_n_oe) |-> io_supply_status;
  endproperty
  a_rst_only_on: assert property (p_rst_only_on)
    else $error("reset driven while module off");
  property p_rst_keeps_pon;
    reset_request_n_oe && $past(reset_request_n_oe) |-> power_on_request_n_oe;
  endproperty
  a_rst_keeps_pon: assert property (p_rst_keeps_pon)
    else $error("power-on released during reset");
  property p_power_up;
    $fell(power_on_request_n_oe) && !with_rst_q |-> ##[1:30] io_supply_status;
  endproperty
  a_power_up: assert property (p_power_up)
    else $error("module not on after ignition");
  property p_wait;
    $fell(power_on_request_n_oe) |-> !power_on_request_n_oe [*8];
  endproperty
  a_wait: assert property (p_wait)
    else $error("power-on driven again during wait");
  property p_rise_cause;
    $rose(io_supply_status) |-> since_q <= 8'h1E;
  endproperty
  a_rise_cause: assert property (p_rise_cause)
    else $error("supply status rose without ignition");
  property p_ind_on;
    $rose(interface_on_indicator) |-> io_supply_status || $past(io_supply_status);
  endproperty
  a_ind_on: assert property (p_ind_on)
    else $error("interface indicator while off");
  // Eight cycles of terminal ready cover the pin latency into the state machine
  property p_awake_ind;
    (!terminal_ready_n) [*8] ##0 io_supply_status |-> interface_on_indicator;
  endproperty
  a_awake_ind: assert property (p_awake_ind)
    else $error("module slept while terminal ready held");

  c_power_on: cover property ($rose(io_supply_status));
  c_reset: cover property ($fell(reset_request_n_oe));
  c_ind: cover property ($rose(interface_on_indicator));
  c_wake: cover property ($changed(wake_request_line));
endmodule
